// ===== rtl/ssw_supervisor.sv
`timescale 1ns/1ps
module ssw_supervisor import ssw_pkg::*; #(
  parameter int HOLD0_CYC = ms_to_cyc(RST_HOLD0_MS),
  parameter int HOLD1_CYC = ms_to_cyc(RST_HOLD1_MS),
  parameter int WD_SHORT_CYC = ms_to_cyc(WD_SHORT_MS),
  parameter int WD_MID_CYC = ms_to_cyc(WD_MID_MS),
  parameter int WD_LONG_CYC = ms_to_cyc(WD_LONG_MS),
  parameter int DEBOUNCE_CYC = ms_to_cyc(DEBOUNCE_MS)
) (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic primarySupplySense, // High while primary is above its trip level.
  input wire logic secondSupplySense, // High while second supply is above its trip.
  input wire logic batteryAboveTrip, // High while battery is above the trip level.
  input wire logic primaryBelowBattLo, // High while primary is below battery-30mV.
  input wire logic primaryAboveBattHi, // High while primary is above battery+30mV.
  input wire logic manualResetInN, // Manual reset, active low.
  input wire logic resetPeriodSelect, // Reset hold time select.
  input wire logic sclIn, // Two-wire clock level.
  input wire logic sdaIn, // Two-wire data level.
  input wire logic hwProtectIn, // Hardware protect pin.
  input wire logic [1:0] nvPeriodIn, // Stored period bits seen at power-up.
  input wire logic statusWrStb, // Status register write strobe.
  input wire logic [1:0] statusWrData, // New period bits.
  input wire logic ctrlWrStb, // Control register write strobe.
  input wire logic [7:0] ctrlWrData, // New control register value.
  input wire logic memWrReq, // Array write request.
  input wire logic [15:0] memWrAddr, // Array write address.
  output logic systemResetN, // System reset, active low.
  output logic lowSupplyN, // Early low-supply warning, active low.
  output logic secondSupplyFailOutN, // Second supply fail, active low.
  output logic watchdogExpiredOutN, // Watchdog expiry, active low.
  output logic supplyPathIndicator, // Low on primary path, high on battery.
  output logic busEnable, // High while bus traffic is accepted.
  output logic [1:0] watchdogPeriod, // Period bits to keep in storage.
  output logic [7:0] ctrlReg, // Control register contents.
  output logic memWrAccept, // One-cycle pulse: array write allowed.
  output logic memWrRefuse // One-cycle pulse: array write refused.
);
  //****************************************************************************
  // Parameter checks
  //****************************************************************************
  generate
    if (HOLD0_CYC < 1 || HOLD1_CYC < 1 || WD_SHORT_CYC < 1 || WD_MID_CYC < 1 ||
        WD_LONG_CYC < 1 || DEBOUNCE_CYC < 1 || HOLD1_CYC >= 2 ** CNT_W ||
        WD_LONG_CYC >= 2 ** CNT_W || HOLD0_CYC >= 2 ** CNT_W) begin : g_chk
      $error("ssw_supervisor: cycle count out of range");
    end
  endgenerate

  //****************************************************************************
  // Input synchronisers and debounce
  //****************************************************************************
  logic [4:0] syncA_ff;
  logic [4:0] syncB_ff;
  logic primOk;
  logic secOk;
  logic battOk;
  logic belowLo;
  logic aboveHi;
  logic mrClean;

  // Comparator outputs are analog-derived and may change at any time.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      syncA_ff <= 5'h00;
      syncB_ff <= 5'h00;
    end else begin
      syncA_ff <= {primarySupplySense, secondSupplySense, batteryAboveTrip,
                   primaryBelowBattLo, primaryAboveBattHi};
      syncB_ff <= syncA_ff;
    end
  end
  assign {primOk, secOk, battOk, belowLo, aboveHi} = syncB_ff;

  ssw_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) uDeb (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rawIn(manualResetInN),
    .cleanOut(mrClean)
  );

  //****************************************************************************
  // Battery switch
  //****************************************************************************
  logic pathBatt_ff;
  logic battMode;

  // Hysteresis: between the two thresholds the path is left where it was.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pathBatt_ff <= 1'b0;
    end else if (primOk) begin
      pathBatt_ff <= 1'b0;
    end else if (belowLo) begin
      pathBatt_ff <= 1'b1;
    end else if (aboveHi) begin
      pathBatt_ff <= 1'b0;
    end
  end
  assign battMode = !primOk && pathBatt_ff;
  assign supplyPathIndicator = pathBatt_ff;

  //****************************************************************************
  // Reset sequencing
  //****************************************************************************
  ssw_rst_state_type state_ff;
  logic [CNT_W-1:0] rstCnt_ff;
  logic [CNT_W-1:0] holdTarget;
  logic resetN_ff;
  logic lowN_ff;

  assign holdTarget = resetPeriodSelect ? CNT_W'(HOLD1_CYC - 1) : CNT_W'(HOLD0_CYC - 1);

  // The early warning tracks the primary comparator directly.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lowN_ff <= 1'b0;
    end else begin
      lowN_ff <= primOk;
    end
  end

  // Power-down delays reset behind the warning; manual reset acts at once.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= ST_ASSERT;
      rstCnt_ff <= '0;
      resetN_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          rstCnt_ff <= '0;
          if (!primOk) begin
            state_ff <= ST_LOWLINE;
          end else if (!mrClean) begin
            state_ff <= ST_ASSERT;
            resetN_ff <= 1'b0;
          end
        end
        ST_LOWLINE: begin
          rstCnt_ff <= rstCnt_ff + CNT_W'(1);
          if (rstCnt_ff == CNT_W'(LOWLINE_CYC - 1)) begin
            state_ff <= ST_ASSERT;
            resetN_ff <= 1'b0;
          end
        end
        ST_ASSERT: begin
          rstCnt_ff <= '0;
          resetN_ff <= 1'b0;
          if (primOk && mrClean) begin
            state_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!primOk || !mrClean) begin
            state_ff <= ST_ASSERT;
            rstCnt_ff <= '0;
          end else if (rstCnt_ff == holdTarget) begin
            state_ff <= ST_RUN;
            resetN_ff <= 1'b1;
          end else begin
            rstCnt_ff <= rstCnt_ff + CNT_W'(1);
          end
        end
        default: begin
          state_ff <= ST_ASSERT;
          resetN_ff <= 1'b0;
        end
      endcase
    end
  end
  assign systemResetN = resetN_ff;
  assign lowSupplyN = lowN_ff;

  //****************************************************************************
  // Second supply monitor
  //****************************************************************************
  logic v2FailN_ff;
  logic monActive;

  assign monActive = primOk || battOk;

  // No hold time: the flag follows the comparator both ways.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      v2FailN_ff <= 1'b1;
    end else if (monActive) begin
      v2FailN_ff <= secOk;
    end
  end
  assign secondSupplyFailOutN = v2FailN_ff;

  //****************************************************************************
  // Bus activity and watchdog
  //****************************************************************************
  logic busEn_ff;
  logic sclD_ff;
  logic sdaD_ff;
  logic armed_ff;
  logic startSeen;
  logic restart;
  logic [1:0] period_ff;
  logic loaded_ff;
  logic [CNT_W-1:0] wdCnt_ff;
  logic [CNT_W-1:0] wdTarget;
  logic wdOffN_ff;
  logic wdOff;
  logic [7:0] ctrl_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busEn_ff <= 1'b0;
    end else begin
      busEn_ff <= primOk && !battMode;
    end
  end
  assign busEnable = busEn_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclD_ff <= 1'b1;
      sdaD_ff <= 1'b1;
    end else begin
      sclD_ff <= sclIn;
      sdaD_ff <= sdaIn;
    end
  end

  // A start arms the restart, the next SCL fall fires it.
  assign startSeen = busEn_ff && sclIn && sclD_ff && sdaD_ff && !sdaIn;
  assign restart = armed_ff && sclD_ff && !sclIn;
  always_ff @(posedge clk_sys) begin
    if (!nrst || !busEn_ff) begin
      armed_ff <= 1'b0;
    end else if (startSeen) begin
      armed_ff <= 1'b1;
    end else if (restart) begin
      armed_ff <= 1'b0;
    end
  end

  // Stored bits are taken once after reset, so a power cycle keeps them.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      period_ff <= WD_OFF;
      loaded_ff <= 1'b0;
    end else if (!loaded_ff) begin
      period_ff <= nvPeriodIn;
      loaded_ff <= 1'b1;
    end else if (statusWrStb && busEn_ff && ctrl_ff[CTRL_WEL_BIT]) begin
      period_ff <= statusWrData;
    end
  end
  assign watchdogPeriod = period_ff;

  always_comb begin
    case (period_ff)
      WD_SHORT: wdTarget = CNT_W'(WD_SHORT_CYC - 1);
      WD_MID: wdTarget = CNT_W'(WD_MID_CYC - 1);
      default: wdTarget = CNT_W'(WD_LONG_CYC - 1);
    endcase
  end
  assign wdOff = period_ff == WD_OFF;

  // Expiry stays low until a host restart, battery mode or the off setting clears it.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wdCnt_ff <= '0;
      wdOffN_ff <= 1'b1;
    end else if (battMode || wdOff || restart) begin
      wdCnt_ff <= '0;
      wdOffN_ff <= 1'b1;
    end else if (wdCnt_ff == wdTarget) begin
      wdOffN_ff <= 1'b0;
    end else begin
      wdCnt_ff <= wdCnt_ff + CNT_W'(1);
    end
  end
  assign watchdogExpiredOutN = wdOffN_ff;

  //****************************************************************************
  // Write protection
  //****************************************************************************
  logic hwLock;
  logic accept_ff;
  logic refuse_ff;

  assign hwLock = hwProtectIn && ctrl_ff[CTRL_HW_PROTECT_ARM_BIT];

  // The latch bit is always writable; protect and arm bits need the latch and no lock.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ctrlWrStb && busEn_ff) begin
      ctrl_ff[CTRL_WEL_BIT] <= ctrlWrData[CTRL_WEL_BIT];
      if (ctrl_ff[CTRL_WEL_BIT] && !hwLock) begin
        ctrl_ff[CTRL_BP_LSB+:3] <= ctrlWrData[CTRL_BP_LSB+:3];
        ctrl_ff[CTRL_HW_PROTECT_ARM_BIT] <= ctrlWrData[CTRL_HW_PROTECT_ARM_BIT];
      end
    end
  end
  assign ctrlReg = ctrl_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      accept_ff <= 1'b0;
      refuse_ff <= 1'b0;
    end else begin
      accept_ff <= memWrReq && busEn_ff && ctrl_ff[CTRL_WEL_BIT] &&
                   ({1'b0, memWrAddr} < prot_start(ctrl_ff[CTRL_BP_LSB+:3]));
      refuse_ff <= memWrReq && !(busEn_ff && ctrl_ff[CTRL_WEL_BIT] &&
                   ({1'b0, memWrAddr} < prot_start(ctrl_ff[CTRL_BP_LSB+:3])));
    end
  end
  assign memWrAccept = accept_ff;
  assign memWrRefuse = refuse_ff;

  //****************************************************************************
  // Assertions
  //****************************************************************************
  reset_on_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(primOk) |-> ##[1:30] !resetN_ff) else $error("reset late after supply loss");
  lowline_lead_a: assert property (@(posedge clk_sys) disable iff (!nrst || primOk)
    $fell(lowN_ff) && resetN_ff |-> ##24 resetN_ff ##[1:50] !resetN_ff)
    else $error("reset not 100 to 300 ns after low-supply");
  hold_release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(resetN_ff) |-> $past(rstCnt_ff) == $past(holdTarget) && $past(primOk))
    else $error("reset released before hold time");
  manual_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !mrClean && state_ff == ST_RUN && primOk |=> !resetN_ff)
    else $error("manual reset not asserted");
  second_fail_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    monActive |=> v2FailN_ff == $past(secOk)) else $error("second fail flag wrong");
  monitor_freeze_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !monActive |=> $stable(v2FailN_ff)) else $error("second fail changed while frozen");
  wd_restart_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    restart |=> wdCnt_ff == '0 && wdOffN_ff) else $error("watchdog not restarted");
  wd_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wdOff |=> wdOffN_ff) else $error("expiry while watchdog off");
  batt_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    battMode |=> wdCnt_ff == '0 && !busEn_ff) else $error("watchdog runs in battery mode");
  path_primary_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    primOk |=> !pathBatt_ff) else $error("battery path with good primary");
  ctrl_lock_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrlWrStb && hwLock |=> $stable(ctrl_ff[CTRL_HW_PROTECT_ARM_BIT]) && $stable(ctrl_ff[CTRL_BP_LSB+:3]))
    else $error("locked control register changed");
  wel_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    memWrReq && !ctrl_ff[CTRL_WEL_BIT] |=> refuse_ff && !accept_ff)
    else $error("write accepted without latch");
endmodule // ssw_supervisor

// ===== rtl/ssw_pkg.sv
//******************************************************************************
// How it works
// - Reset releases only after primary stays good for hold time, 150 or 600 ms.
// - Primary below trip asserts system reset within 20 us.
// - Bus traffic is ignored while primary supply is below trip.
// - Power-down: early low-supply first, system reset 100 to 300 ns later.
// - Second-supply fail follows its comparator with no hold time.
// - Second-supply monitoring freezes when primary and battery are both low.
// - Watchdog restarts on first SCL fall after a start condition.
// - Period bits 10, 01, 00 give 150, 400, 800 ms.
// - Watchdog stays off in the factory default setting.
// - Period bits are nonvolatile and written through the status write port.
// - Battery backup mode stops and clears the watchdog timebase.
// - Path goes to battery below batt-30mV, back above batt+30mV.
// - Path indicator is low on primary path, high on battery path.
// - Battery mode when primary low and below battery: reset, bus refused.
// - Manual reset low asserts reset, held for hold time after release.
// - Manual reset input is debounced internally.
// - Nonvolatile writes are blocked until the write-enable latch is set.
// - Three protect bits choose one of eight protected block ranges.
// - Protect pin high with arm bit set freezes the protect and arm bits of the control register.
// - Protect pin low disables hardware protection regardless of arm bit.
//******************************************************************************
package ssw_pkg;
  localparam int CLK_MHZ = 250;
  localparam int RST_HOLD0_MS = 150;
  localparam int RST_HOLD1_MS = 600;
  localparam int WD_SHORT_MS = 150;
  localparam int WD_MID_MS = 400;
  localparam int WD_LONG_MS = 800;
  localparam int DEBOUNCE_MS = 5;
  localparam int LOWLINE_MIN_NS = 100;
  // Least time, so round up to whole cycles.
  localparam int LOWLINE_CYC = (LOWLINE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 28;

  // Watchdog period encodings.
  localparam logic [1:0] WD_SHORT = 2'h2;
  localparam logic [1:0] WD_MID = 2'h1;
  localparam logic [1:0] WD_LONG = 2'h0;
  localparam logic [1:0] WD_OFF = 2'h3;

  // Control register layout.
  localparam int CTRL_WEL_BIT = 1;
  localparam int CTRL_BP_LSB = 2;
  localparam int CTRL_HW_PROTECT_ARM_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {ST_RUN, ST_LOWLINE, ST_ASSERT, ST_HOLD} ssw_rst_state_type;

  // Converts milliseconds to clock cycles.
  function automatic int ms_to_cyc(input int ms);
    ms_to_cyc = ms * CLK_MHZ * 1000;
  endfunction

  // First protected address for each protect choice; 17'h10000 protects nothing.
  function automatic logic [16:0] prot_start(input logic [2:0] bp);
    case (bp)
      3'h0: prot_start = 17'h10000;
      3'h1: prot_start = 17'h0C000;
      3'h2: prot_start = 17'h08000;
      3'h3: prot_start = 17'h00000;
      3'h4: prot_start = 17'h0E000;
      3'h5: prot_start = 17'h0F000;
      3'h6: prot_start = 17'h0F800;
      default: prot_start = 17'h0FC00;
    endcase
  endfunction
endpackage

// ===== rtl/ssw_debounce.sv
`timescale 1ns/1ps
// Passes a level on only after it has stayed steady for STABLE_CYC cycles.
module ssw_debounce #(
  parameter int STABLE_CYC = 1250000
) (
  input wire logic clk_sys, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic rawIn, // Bouncy input level.
  output logic cleanOut // Debounced level.
);
  logic [23:0] cnt_ff;
  logic last_ff;
  logic clean_ff;

  generate
    if (STABLE_CYC < 1 || STABLE_CYC >= 2 ** 24) begin : g_chk
      $error("ssw_debounce: STABLE_CYC out of range");
    end
  endgenerate

  // A change restarts the count, so a bouncing contact never gets through.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_ff <= 24'h000000;
      last_ff <= 1'b1;
      clean_ff <= 1'b1;
    end else if (rawIn != last_ff) begin
      last_ff <= rawIn;
      cnt_ff <= 24'h000000;
    end else if (cnt_ff == 24'(STABLE_CYC - 1)) begin
      clean_ff <= last_ff;
    end else begin
      cnt_ff <= cnt_ff + 24'h000001;
    end
  end

  assign cleanOut = clean_ff;
endmodule // ssw_debounce

// ===== testbench/ssw_host_model.sv
`timescale 1ns/1ps
// Host processor on the two-wire bus: each kick sends a start, one SCL fall and a stop.
module ssw_host_model (
  input wire logic clk_sys, // System clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic kickReq, // One-cycle request for a restart frame.
  output logic sclLine, // Bus clock level.
  output logic sdaLine, // Bus data level.
  output logic kickDone // High in the cycle after SCL falls.
);
  logic [2:0] phase_ff;

  // Frame sequencer; a kick during a frame is dropped, so frames never overlap.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase_ff <= 3'h0;
    end else if (phase_ff != 3'h0 || kickReq) begin
      phase_ff <= phase_ff + 3'h1;
    end
  end

  // Lines rest high between frames, as the pull-ups leave them; start at 1, stop at 7.
  assign sdaLine = (phase_ff == 3'h0) || (phase_ff == 3'h7);
  assign sclLine = !((phase_ff == 3'h3) || (phase_ff == 3'h4));
  assign kickDone = (phase_ff == 3'h4);
endmodule // ssw_host_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ssw_pkg::*;
  localparam int H0 = 60;
  localparam int H1 = 120;
  localparam logic [1:0] WCODE [3] = '{2'h2, 2'h1, 2'h0};
  localparam int WCYC [3] = '{80, 120, 160};
  localparam logic [16:0] PST [8] = '{17'h10000, 17'h0C000, 17'h08000, 17'h00000,
    17'h0E000, 17'h0F000, 17'h0F800, 17'h0FC00};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic prim = 1'b1, sec = 1'b1, batt = 1'b1, belowLo = 1'b0, aboveHi = 1'b1;
  logic manN = 1'b1, rsel = 1'b0, hwp = 1'b0, kickReq = 1'b0;
  logic sWr = 1'b0, cWr = 1'b0, mWr = 1'b0;
  logic [1:0] nvPer = 2'h3, sData = 2'h0;
  logic [7:0] cData = 8'h00;
  logic [15:0] mAddr = 16'h0000;
  logic scl, sda, kickDone, rstN, lowN, failN, wdoN, path, busEn, acc, ref_;
  logic [1:0] wdPer;
  logic [7:0] ctrl;
  int errors = 0;
  int n_tests = 0;

  //****************************************
  // Clock, host model and device
  //****************************************
  // Half period of 2 ns gives 250 MHz.
  always #2 clk_sys = !clk_sys;

  ssw_host_model i_host (.clk_sys(clk_sys), .nrst(nrst), .kickReq(kickReq),
    .sclLine(scl), .sdaLine(sda), .kickDone(kickDone));

  ssw_supervisor #(.HOLD0_CYC(H0), .HOLD1_CYC(H1), .WD_SHORT_CYC(80), .WD_MID_CYC(120),
    .WD_LONG_CYC(160), .DEBOUNCE_CYC(4)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .primarySupplySense(prim), .secondSupplySense(sec),
    .batteryAboveTrip(batt), .primaryBelowBattLo(belowLo), .primaryAboveBattHi(aboveHi),
    .manualResetInN(manN), .resetPeriodSelect(rsel), .sclIn(scl), .sdaIn(sda),
    .hwProtectIn(hwp), .nvPeriodIn(nvPer), .statusWrStb(sWr), .statusWrData(sData),
    .ctrlWrStb(cWr), .ctrlWrData(cData), .memWrReq(mWr), .memWrAddr(mAddr),
    .systemResetN(rstN), .lowSupplyN(lowN), .secondSupplyFailOutN(failN),
    .watchdogExpiredOutN(wdoN), .supplyPathIndicator(path), .busEnable(busEn),
    .watchdogPeriod(wdPer), .ctrlReg(ctrl), .memWrAccept(acc), .memWrRefuse(ref_));

  //****************************************
  // Access and compare tasks
  //****************************************
  // Inputs move 1 ns after the edge so no race with the design's sampling.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = rstN;
      1: pick = wdoN;
      2: pick = lowN;
      3: pick = failN;
      4: pick = path;
      default: pick = kickDone;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits at most hi cycles for a level; arriving before lo cycles is also a mismatch.
  task automatic wt(input string nm, input int k, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(k) !== lvl && n < hi) begin
      cyc(1);
      n++;
    end
    n_tests++;
    if (pick(k) !== lvl) begin
      errors++;
      $display("[ERR] %s expected %b within %0d cycles seen %b", nm, lvl, hi, pick(k));
      give_verdict();
    end else if (n < lo) begin
      errors++;
      $display("[ERR] %s expected after %0d cycles seen after %0d", nm, lo, n);
    end
  endtask

  task automatic wrc(input logic [7:0] d);
    cData = d;
    cWr = 1'b1;
    cyc(1);
    cWr = 1'b0;
    cyc(1);
  endtask

  task automatic wrs(input logic [1:0] d);
    sData = d;
    sWr = 1'b1;
    cyc(1);
    sWr = 1'b0;
    cyc(1);
  endtask

  // The verdict pulse stands one cycle, so it is looked at right after the request edge.
  task automatic memw(input logic [15:0] a, input logic ok);
    mAddr = a;
    mWr = 1'b1;
    cyc(1);
    mWr = 1'b0;
    chk("memWrAccept", {7'h0, ok}, {7'h0, acc});
    chk("memWrRefuse", {7'h0, !ok}, {7'h0, ref_});
    cyc(1);
  endtask

  // The frame runs three more cycles after kickDone; waiting them out keeps the next kick
  // from landing inside a frame, where the host model would drop it.
  task automatic kick();
    kickReq = 1'b1;
    cyc(1);
    kickReq = 1'b0;
    wt("kickDone", 5, 1'b1, 0, 10);
    cyc(4);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //****************************************
  // Test sequence
  //****************************************
  initial begin
    cyc(20);
    nrst = 1'b1;
    wt("releaseShort", 0, 1'b1, H0 - 2, H0 + 12);
    chk("watchdogPeriod", 8'h03, {6'h0, wdPer});
    chk("ctrlReg", 8'h00, ctrl);
    $display("test powerUp done");
    memw(16'h0000, 1'b0);
    wrs(2'h2);
    chk("watchdogPeriod", 8'h03, {6'h0, wdPer});
    wrc(8'h02);
    chk("ctrlReg", 8'h02, ctrl);
    // Top and bottom address against each of the eight protect choices.
    for (int i = 0; i < 8; i++) begin
      wrc(8'h02 | 8'(i << 2));
      memw(16'hFFFF, 17'h0FFFF < PST[i]);
      memw(16'h0000, 17'h00000 < PST[i]);
    end
    // Protect pin moves only between bus frames.
    wrc(8'h82);
    hwp = 1'b1;
    wrc(8'h0E);
    chk("ctrlReg", 8'h82, ctrl);
    hwp = 1'b0;
    wrc(8'h06);
    chk("ctrlReg", 8'h06, ctrl);
    wrc(8'h02);
    $display("test protect done");
    for (int i = 0; i < 3; i++) begin
      wrs(WCODE[i]);
      chk("watchdogPeriod", {6'h0, WCODE[i]}, {6'h0, wdPer});
      kick();
      wt("expiry", 1, 1'b0, WCYC[i] - 8, WCYC[i] + 10);
      kick();
      wt("restart", 1, 1'b1, 0, 6);
    end
    wrs(2'h3);
    kick();
    cyc(250);
    chk("expiryOff", 8'h01, {7'h0, wdoN});
    $display("test watchdog done");
    sec = 1'b0;
    wt("secondFail", 3, 1'b0, 0, 8);
    sec = 1'b1;
    wt("secondOk", 3, 1'b1, 0, 8);
    $display("test second done");
    // A two-cycle bounce must not reach the reset output.
    manN = 1'b0;
    cyc(2);
    manN = 1'b1;
    cyc(12);
    chk("bounce", 8'h01, {7'h0, rstN});
    manN = 1'b0;
    wt("manualOn", 0, 1'b0, 2, 14);
    cyc(20);
    manN = 1'b1;
    wt("manualOff", 0, 1'b1, H0, H0 + 20);
    $display("test manual done");
    wrs(2'h2);
    kick();
    wt("expiry", 1, 1'b0, 0, 100);
    rsel = 1'b1;
    prim = 1'b0;
    wt("lowSupply", 2, 1'b0, 0, 8);
    wt("lowToReset", 0, 1'b0, 25, 75);
    chk("busEnable", 8'h00, {7'h0, busEn});
    belowLo = 1'b1;
    aboveHi = 1'b0;
    wt("pathBatt", 4, 1'b1, 0, 8);
    wt("expiryClr", 1, 1'b1, 0, 8);
    cyc(100);
    chk("expiryStop", 8'h01, {7'h0, wdoN});
    chk("battReset", 8'h00, {7'h0, rstN});
    chk("battBus", 8'h00, {7'h0, busEn});
    batt = 1'b0;
    sec = 1'b0;
    cyc(10);
    chk("secondFrozen", 8'h01, {7'h0, failN});
    batt = 1'b1;
    wt("secondResume", 3, 1'b0, 0, 8);
    sec = 1'b1;
    belowLo = 1'b0;
    aboveHi = 1'b1;
    wt("pathPrim", 4, 1'b0, 0, 8);
    prim = 1'b1;
    wt("releaseLong", 0, 1'b1, H1 - 2, H1 + 12);
    $display("test power done");
    give_verdict();
  end
endmodule // tb_top
